// ### rtl/hot_swap_regmap.sv
`default_nettype none
// Summary of operation
// - Slave address is 001 plus strap-selected index, eight choices from 20h to 2Eh.
// - Writes to mass-write address are accepted for every strap setting except broadcast.
// - Alert response read acknowledged only while alert is active; returns own address.
// - High-order strap high and low-order strap low selects broadcast, disabling serial.
// - Only the command byte low nibble becomes the register pointer.
// - Register pointer survives transaction end; receive-byte reads repeat it.
// - ADC result registers accept bus writes only while the unlock control bit is set.
// - Live status sits at 00h and ignores bus writes.
// - Status bit 7 follows the pass switch drive state.
// - Status bit 6 shows multipurpose pin level when configured as general input.
// - Status bit 5 set while sense exceeds 2mV with switch commanded off.
// - Status bit 4 shows the board-present pin level.
// - Status bit 3 set when power-good input still low at check timer expiry.
// - Status bit 2 set while overcurrent is present.
// - Status bit 1 set only while both undervoltage inputs are low.
// - Status bit 0 follows the overvoltage input.
// - Fault log is read/write and holds latched faults and multipurpose events.
// - Alert enable register is read/write and gates which faults raise alert.
// - Control register is read/write; selects retry and commanded switch state.
// - Current result: eight MSBs in one register, two LSBs in the next.
// - Second auxiliary result split into eight-bit high and two-bit low registers.
// - First auxiliary result split into eight-bit high and two-bit low registers.
module hot_swap_regmap (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [1:0] i_strap_pin_low_order,
  input wire logic [1:0] i_strap_pin_high_order,
  input wire logic i_multipurpose_good_pin,
  input wire logic i_board_present_n,
  input wire logic i_undervolt_high_input,
  input wire logic i_undervolt_low_input,
  input wire logic i_overvolt_input,
  input wire logic i_fet_on,
  input wire logic i_sense_above_2mv,
  input wire logic i_power_bad,
  input wire logic i_overcurrent,
  input wire logic i_alert_active,
  input wire logic [7:0] i_fault_set,
  input wire logic i_adc_load,
  input wire logic [1:0] i_adc_chan,
  input wire logic [9:0] i_adc_value,
  input wire logic i_addr_valid,
  input wire logic [6:0] i_addr,
  input wire logic i_addr_rw,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_byte,
  input wire logic i_wdata_valid,
  input wire logic [7:0] i_wdata,
  input wire logic i_rdata_req,
  input wire logic i_stop,
  output logic o_addr_ack_valid,
  output logic o_addr_ack,
  output logic o_rdata_valid,
  output logic [7:0] o_rdata,
  output logic o_two_wire_enable,
  output logic [6:0] o_own_addr,
  output logic [7:0] o_fault_log,
  output logic [7:0] o_alert_enable,
  output logic [7:0] o_switch_control
);
  import hot_swap_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [8:0] sync1_reg;
  logic [8:0] sync2_reg;
  wire [8:0] pins_raw = {i_strap_pin_high_order, i_strap_pin_low_order, i_multipurpose_good_pin,
                         i_board_present_n, i_undervolt_high_input, i_undervolt_low_input, i_overvolt_input};

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1_reg <= 9'h000;
      sync2_reg <= 9'h000;
    end else if (i_clk_en) begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  wire [1:0] strap_hi_s = sync2_reg[8:7];
  wire [1:0] strap_lo_s = sync2_reg[6:5];
  wire mpg_s = sync2_reg[4];
  wire bp_s = sync2_reg[3];
  wire uvh_s = sync2_reg[2];
  wire uvl_s = sync2_reg[1];
  wire ov_s = sync2_reg[0];

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  addr_decode_if dif ();
  assign dif.strap_lo = strap_lo_s;
  assign dif.strap_hi = strap_hi_s;
  assign dif.addr = i_addr;
  assign dif.alert_active = i_alert_active;

  slave_addr_decode u_decode (
    .dec(dif.decoder)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] fault_log_reg;
  logic [7:0] alert_enable_reg;
  logic [7:0] switch_control_reg;
  logic [7:0] adc_reg [0:5];
  logic [3:0] ptr_reg;
  txn_t txn_reg;
  txn_t txn_next;

  wire gp_input_cfg = switch_control_reg[CTRL_CFG_HI:CTRL_CFG_LO] == CFG_GP_INPUT;
  wire adc_unlock = switch_control_reg[CTRL_ADC_UNLOCK];

  wire [7:0] live_status = {i_fet_on,
                            gp_input_cfg & mpg_s,
                            i_sense_above_2mv & ~switch_control_reg[CTRL_SWITCH_ON],
                            bp_s,
                            i_power_bad,
                            i_overcurrent,
                            ~uvh_s & ~uvl_s,
                            ov_s};

  // Transaction events
  wire addr_take = i_addr_valid && !dif.broadcast;
  wire addr_write_hit = !i_addr_rw && (dif.hit_own || dif.hit_mass);
  wire addr_read_hit = i_addr_rw && dif.hit_own;
  wire addr_alert_hit = i_addr_rw && dif.hit_alert;
  wire addr_acked = addr_take && (addr_write_hit || addr_read_hit || addr_alert_hit);
  wire cmd_take = i_cmd_valid && txn_reg == TXN_CMD;
  wire wr_take = i_wdata_valid && txn_reg == TXN_DATA;
  wire adc_target = ptr_reg >= REG_CURRENT_HIGH && ptr_reg <= REG_LAST;
  wire [2:0] adc_wr_idx = 3'(ptr_reg - REG_CURRENT_HIGH);
  wire adc_bus_wr = wr_take && adc_target && adc_unlock;
  wire rd_take = i_rdata_req && (txn_reg == TXN_READ || txn_reg == TXN_ALERT);

  // Register read selection; unmapped reads return zero
  function automatic logic [7:0] reg_read(input logic [3:0] p, input logic [7:0] st,
                                          input logic [7:0] fl, input logic [7:0] ae,
                                          input logic [7:0] sc, input logic [7:0] ar [0:5]);
    logic [7:0] v;
    v = UNMAPPED_READ;
    if (p == REG_LIVE_STATUS) begin
      v = st;
    end else if (p == REG_FAULT_LOG) begin
      v = fl;
    end else if (p == REG_ALERT_ENABLE) begin
      v = ae;
    end else if (p == REG_SWITCH_CONTROL) begin
      v = sc;
    end else if (p <= REG_LAST) begin
      v = ar[3'(p - REG_CURRENT_HIGH)];
    end
    return v;
  endfunction : reg_read

  wire [7:0] rd_value = (txn_reg == TXN_ALERT) ? {dif.own_addr, 1'b0} :
                        reg_read(ptr_reg, live_status, fault_log_reg, alert_enable_reg,
                                 switch_control_reg, adc_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Transaction sequencer
  always_comb begin
    txn_next = txn_reg;
    if (i_stop) begin
      txn_next = TXN_IDLE;
    end else if (i_addr_valid) begin
      if (!addr_acked) begin
        txn_next = TXN_IDLE;
      end else if (addr_write_hit) begin
        txn_next = TXN_CMD;
      end else if (addr_read_hit) begin
        txn_next = TXN_READ;
      end else begin
        txn_next = TXN_ALERT;
      end
    end else if (cmd_take) begin
      txn_next = TXN_DATA;
    end else if (wr_take) begin
      txn_next = TXN_IGNORE;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      txn_reg <= TXN_IDLE;
      ptr_reg <= PTR_RST;
    end else if (i_clk_en) begin
      txn_reg <= txn_next;
      if (cmd_take) begin
        ptr_reg <= i_cmd_byte[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fault_log_reg <= FAULT_LOG_RST;
      alert_enable_reg <= ALERT_ENABLE_RST;
      switch_control_reg <= SWITCH_CONTROL_RST;
    end else if (i_clk_en) begin
      fault_log_reg <= ((wr_take && ptr_reg == REG_FAULT_LOG) ? i_wdata : fault_log_reg) | i_fault_set;
      if (wr_take && ptr_reg == REG_ALERT_ENABLE) begin
        alert_enable_reg <= i_wdata;
      end
      if (wr_take && ptr_reg == REG_SWITCH_CONTROL) begin
        switch_control_reg <= i_wdata;
      end
    end
  end

  // Conversion results; a conversion wins over a same-cycle bus write to that channel
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int k = 0; k < 6; k++) begin
        adc_reg[k] <= ADC_RST;
      end
    end else if (i_clk_en) begin
      if (adc_bus_wr) begin
        adc_reg[adc_wr_idx] <= i_wdata;
      end
      if (i_adc_load) begin
        adc_reg[{i_adc_chan, 1'b0}] <= i_adc_value[ADC_BITS-1 -: 8];
        adc_reg[{i_adc_chan, 1'b1}] <= 8'(i_adc_value[1:0]) << ADC_LOW_POS;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_addr_ack_valid <= 1'b0;
      o_addr_ack <= 1'b0;
      o_rdata_valid <= 1'b0;
      o_rdata <= RDATA_IDLE;
      o_two_wire_enable <= 1'b0;
      o_own_addr <= 7'h00;
      o_fault_log <= FAULT_LOG_RST;
      o_alert_enable <= ALERT_ENABLE_RST;
      o_switch_control <= SWITCH_CONTROL_RST;
    end else if (i_clk_en) begin
      o_addr_ack_valid <= i_addr_valid;
      o_addr_ack <= i_addr_valid && addr_acked;
      o_rdata_valid <= i_rdata_req;
      o_rdata <= rd_take ? rd_value : RDATA_IDLE;
      o_two_wire_enable <= !dif.broadcast;
      o_own_addr <= dif.own_addr;
      o_fault_log <= fault_log_reg;
      o_alert_enable <= alert_enable_reg;
      o_switch_control <= switch_control_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  wire status_rd = i_clk_en && rd_take && txn_reg == TXN_READ && ptr_reg == REG_LIVE_STATUS;
  broadcast_nack_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_clk_en && i_addr_valid && dif.broadcast |=> !o_addr_ack)
    else $error("address acknowledged in broadcast mode");

  own_addr_range_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !dif.broadcast |-> dif.own_addr[6:4] == ADDR_UPPER && dif.own_addr[3] == 1'b0)
    else $error("own address out of range");

  mass_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_clk_en && i_addr_valid && !i_addr_rw && i_addr == MASS_WRITE_ADDR && !dif.broadcast
    |=> o_addr_ack && txn_reg == TXN_CMD)
    else $error("mass write not accepted");

  alert_gate_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_clk_en && i_addr_valid && i_addr_rw && i_addr == ALERT_RESP_ADDR && !i_alert_active
    && dif.own_addr != ALERT_RESP_ADDR |=> !o_addr_ack)
    else $error("alert response acknowledged while alert released");

  ptr_nibble_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_clk_en && cmd_take |=> ptr_reg == $past(i_cmd_byte[3:0]))
    else $error("pointer not loaded from command nibble");

  ptr_keep_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_clk_en && i_stop && !cmd_take |=> $stable(ptr_reg))
    else $error("pointer lost at transaction end");

  adc_lock_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_clk_en && wr_take && adc_target && !adc_unlock && !i_adc_load
    |=> adc_reg[$past(adc_wr_idx)] == $past(adc_reg[adc_wr_idx]))
    else $error("locked result register changed by bus write");

  status_read_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_clk_en && rd_take && txn_reg == TXN_READ && ptr_reg == REG_LIVE_STATUS |=> o_rdata == $past(live_status))
    else $error("status read mismatch");

  undervolt_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    live_status[ST_UNDERVOLT] == (!uvh_s && !uvl_s))
    else $error("undervoltage status wrong");

  fault_set_wins_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_clk_en && i_fault_set != 8'h00 |=> (fault_log_reg & $past(i_fault_set)) == $past(i_fault_set))
    else $error("fault event lost");

  unmapped_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_clk_en && rd_take && txn_reg == TXN_READ && ptr_reg > REG_LAST |=> o_rdata == UNMAPPED_READ)
    else $error("unmapped register read not zero");

  own_ack_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_clk_en && i_addr_valid && !dif.broadcast && i_addr == dif.own_addr |=> o_addr_ack_valid && o_addr_ack)
    else $error("own address not acknowledged");

  fet_status_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    status_rd |=> o_rdata[ST_FET_ON] == $past(i_fet_on))
    else $error("switch state bit wrong");

  gp_status_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    status_rd && gp_input_cfg |=> o_rdata[ST_GP_INPUT] == $past(mpg_s))
    else $error("general input bit wrong");

  short_status_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    status_rd |=> o_rdata[ST_FET_SHORT] == $past(i_sense_above_2mv && !switch_control_reg[CTRL_SWITCH_ON]))
    else $error("switch short bit wrong");

  present_status_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    status_rd |=> o_rdata[ST_BOARD_PRESENT] == $past(bp_s))
    else $error("board present bit wrong");

  power_bad_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    status_rd |=> o_rdata[ST_POWER_BAD] == $past(i_power_bad))
    else $error("power bad bit wrong");

  overcurrent_status_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    status_rd |=> o_rdata[ST_OVERCURRENT] == $past(i_overcurrent))
    else $error("overcurrent bit wrong");

  overvolt_status_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    status_rd |=> o_rdata[ST_OVERVOLT] == $past(ov_s))
    else $error("overvoltage bit wrong");

  alert_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_clk_en && wr_take && ptr_reg == REG_ALERT_ENABLE |=> alert_enable_reg == $past(i_wdata))
    else $error("alert enable write lost");

  ctrl_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_clk_en && wr_take && ptr_reg == REG_SWITCH_CONTROL |=> switch_control_reg == $past(i_wdata))
    else $error("control write lost");

  current_split_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_clk_en && i_adc_load && i_adc_chan == ADC_CH_CURRENT |=> adc_reg[0] == $past(i_adc_value[9:2])
    && adc_reg[1] == {6'h00, $past(i_adc_value[1:0])})
    else $error("current result split wrong");

  aux_two_split_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_clk_en && i_adc_load && i_adc_chan == ADC_CH_AUX_TWO |=> adc_reg[2] == $past(i_adc_value[9:2])
    && adc_reg[3] == {6'h00, $past(i_adc_value[1:0])})
    else $error("second auxiliary result split wrong");

  aux_one_split_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_clk_en && i_adc_load && i_adc_chan == ADC_CH_AUX_ONE |=> adc_reg[4] == $past(i_adc_value[9:2])
    && adc_reg[5] == {6'h00, $past(i_adc_value[1:0])})
    else $error("first auxiliary result split wrong");

endmodule : hot_swap_regmap
`default_nettype wire

// ### rtl/hot_swap_pkg.sv
`default_nettype none
package hot_swap_pkg;

  // Register indices taken from the low nibble of the command byte
  localparam logic [3:0] REG_LIVE_STATUS = 4'h0;
  localparam logic [3:0] REG_FAULT_LOG = 4'h1;
  localparam logic [3:0] REG_ALERT_ENABLE = 4'h2;
  localparam logic [3:0] REG_SWITCH_CONTROL = 4'h3;
  localparam logic [3:0] REG_CURRENT_HIGH = 4'h4;
  localparam logic [3:0] REG_CURRENT_LOW = 4'h5;
  localparam logic [3:0] REG_AUX_TWO_HIGH = 4'h6;
  localparam logic [3:0] REG_AUX_TWO_LOW = 4'h7;
  localparam logic [3:0] REG_AUX_ONE_HIGH = 4'h8;
  localparam logic [3:0] REG_AUX_ONE_LOW = 4'h9;
  localparam logic [3:0] REG_LAST = 4'h9;

  // Serial addresses, seven-bit form
  localparam logic [2:0] ADDR_UPPER = 3'h1;
  localparam logic [6:0] MASS_WRITE_ADDR = 7'h1f;
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;

  // Live status bit positions
  localparam int ST_FET_ON = 7;
  localparam int ST_GP_INPUT = 6;
  localparam int ST_FET_SHORT = 5;
  localparam int ST_BOARD_PRESENT = 4;
  localparam int ST_POWER_BAD = 3;
  localparam int ST_OVERCURRENT = 2;
  localparam int ST_UNDERVOLT = 1;
  localparam int ST_OVERVOLT = 0;

  // Control fields
  localparam int CTRL_ADC_UNLOCK = 5;
  localparam int CTRL_SWITCH_ON = 3;
  localparam int CTRL_CFG_HI = 7;
  localparam int CTRL_CFG_LO = 6;
  localparam logic [1:0] CFG_GP_INPUT = 2'h3;

  // ADC result layout
  localparam int ADC_BITS = 10;
  localparam int ADC_LOW_POS = 0;
  localparam logic [1:0] ADC_CH_CURRENT = 2'h0;
  localparam logic [1:0] ADC_CH_AUX_TWO = 2'h1;
  localparam logic [1:0] ADC_CH_AUX_ONE = 2'h2;

  // Values after reset and idle answers
  localparam logic [7:0] FAULT_LOG_RST = 8'h00;
  localparam logic [7:0] ALERT_ENABLE_RST = 8'h00;
  localparam logic [7:0] SWITCH_CONTROL_RST = 8'h00;
  localparam logic [7:0] ADC_RST = 8'h00;
  localparam logic [3:0] PTR_RST = 4'h0;
  localparam logic [7:0] RDATA_IDLE = 8'hff;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  typedef enum logic [1:0] {
    STRAP_LOW = 2'b00,
    STRAP_HIGH = 2'b01,
    STRAP_OPEN = 2'b10
  } strap_t;

  typedef enum logic [2:0] {
    TXN_IDLE = 3'b000,
    TXN_CMD = 3'b001,
    TXN_DATA = 3'b010,
    TXN_IGNORE = 3'b011,
    TXN_READ = 3'b100,
    TXN_ALERT = 3'b101
  } txn_t;

endpackage : hot_swap_pkg
`default_nettype wire

// ### rtl/addr_decode_if.sv
`default_nettype none
interface addr_decode_if;
  import hot_swap_pkg::*;
  logic [1:0] strap_lo;
  logic [1:0] strap_hi;
  logic [6:0] addr;
  logic alert_active;
  logic [6:0] own_addr;
  logic broadcast;
  logic hit_own;
  logic hit_mass;
  logic hit_alert;
  modport decoder (input strap_lo, strap_hi, addr, alert_active,
                   output own_addr, broadcast, hit_own, hit_mass, hit_alert);
  modport user (output strap_lo, strap_hi, addr, alert_active,
                input own_addr, broadcast, hit_own, hit_mass, hit_alert);
endinterface : addr_decode_if
`default_nettype wire

// ### rtl/slave_addr_decode.sv
`default_nettype none
module slave_addr_decode (
  addr_decode_if.decoder dec
);
  import hot_swap_pkg::*;

  // Strap pair to address index; bit 3 flags broadcast; an unused code counts as open
  function automatic logic [3:0] strap_index(input logic [1:0] hi, input logic [1:0] lo);
    logic [3:0] idx;
    logic [1:0] h;
    logic [1:0] l;
    idx = 4'h0;
    h = (hi == 2'h3) ? STRAP_OPEN : hi;
    l = (lo == 2'h3) ? STRAP_OPEN : lo;
    unique case ({h, l})
      {STRAP_LOW, STRAP_LOW}: idx = 4'h0;
      {STRAP_LOW, STRAP_OPEN}: idx = 4'h1;
      {STRAP_HIGH, STRAP_OPEN}: idx = 4'h2;
      {STRAP_LOW, STRAP_HIGH}: idx = 4'h3;
      {STRAP_OPEN, STRAP_LOW}: idx = 4'h4;
      {STRAP_OPEN, STRAP_OPEN}: idx = 4'h5;
      {STRAP_HIGH, STRAP_HIGH}: idx = 4'h6;
      {STRAP_OPEN, STRAP_HIGH}: idx = 4'h7;
      {STRAP_HIGH, STRAP_LOW}: idx = 4'h8;
      default: idx = 4'h5;
    endcase
    return idx;
  endfunction : strap_index

  wire [3:0] idx = strap_index(dec.strap_hi, dec.strap_lo);

  assign dec.broadcast = idx[3];
  assign dec.own_addr = {ADDR_UPPER, 1'b0, idx[2:0]};
  assign dec.hit_own = !idx[3] && (dec.addr == dec.own_addr);
  assign dec.hit_mass = !idx[3] && (dec.addr == MASS_WRITE_ADDR);
  assign dec.hit_alert = !idx[3] && dec.alert_active && (dec.addr == ALERT_RESP_ADDR);

endmodule : slave_addr_decode
`default_nettype wire

// ### sim/bus_master_model.sv
`default_nettype none
module bus_master_model (
  input wire logic i_core_clk,
  input wire logic i_ack_valid,
  input wire logic i_ack,
  input wire logic i_rdata_valid,
  input wire logic [7:0] i_rdata,
  output logic o_addr_valid,
  output logic [6:0] o_addr,
  output logic o_rw,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd,
  output logic o_wdata_valid,
  output logic [7:0] o_wdata,
  output logic o_rdata_req,
  output logic o_stop
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last_ack;
  logic addr_ack;
  logic [7:0] last_data;
  initial begin
    {o_addr_valid, o_cmd_valid, o_wdata_valid, o_rdata_req, o_stop} = 5'h00;
    o_addr = 7'h00;
    o_rw = 1'b0;
    o_cmd = 8'h00;
    o_wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////////
  // One request pulse: 0 addr write, 1 addr read, 2 cmd, 3 data, 4 read, 5 stop
  task automatic step(input logic [2:0] kind, input logic [7:0] v);
    @(posedge i_core_clk);
    o_addr <= v[6:0];
    o_rw <= kind[0];
    o_cmd <= v;
    o_wdata <= v;
    o_addr_valid <= (kind <= 3'h1);
    o_cmd_valid <= (kind == 3'h2);
    o_wdata_valid <= (kind == 3'h3);
    o_rdata_req <= (kind == 3'h4);
    o_stop <= (kind == 3'h5);
    @(posedge i_core_clk);
    {o_addr_valid, o_cmd_valid, o_wdata_valid, o_rdata_req, o_stop} <= 5'h00;
    #1;
    last_ack = i_ack_valid & i_ack;
    if (kind == 3'h4) begin
      last_data = i_rdata_valid ? i_rdata : 8'hee;
    end
  endtask : step
  // Write byte transaction
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d);
    step(3'h0, {1'b0, a});
    addr_ack = last_ack;
    step(3'h2, c);
    step(3'h3, d);
    step(3'h5, 8'h00);
  endtask : wr
  // Read byte transaction with repeated start
  task automatic rd(input logic [6:0] a, input logic [7:0] c);
    step(3'h0, {1'b0, a});
    step(3'h2, c);
    step(3'h1, {1'b0, a});
    addr_ack = last_ack;
    step(3'h4, 8'h00);
    step(3'h5, 8'h00);
  endtask : rd
endmodule : bus_master_model
`default_nettype wire

// ### sim/test_hot_swap_regmap.sv
`default_nettype none
module test_hot_swap_regmap;
  timeunit 1ns;
  timeprecision 100ps;
  import hot_swap_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] s_lo = 2'h0, s_hi = 2'h0;
  logic pg = 1'b0, bp_n = 1'b0, undervolt_high_input = 1'b0, undervolt_low_input = 1'b0, ov = 1'b0;
  logic fet = 1'b0, sense = 1'b0, pbad = 1'b0, oc = 1'b0, alert = 1'b0;
  logic [7:0] fset = 8'h00;
  logic ld = 1'b0;
  logic [1:0] ch = 2'h0;
  logic [9:0] val = 10'h000;
  wire logic av, rw, cv, wv, rq, sp, ackv, ack, rv, twe;
  wire logic [6:0] a, own;
  wire logic [7:0] c, wd, rdat, fl, ae, sc;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  logic [1:0] hi_tab [0:8] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h2, 2'h1, 2'h2, 2'h1};
  logic [1:0] lo_tab [0:8] = '{2'h0, 2'h2, 2'h2, 2'h1, 2'h0, 2'h2, 2'h1, 2'h1, 2'h0};
  logic [7:0] p;
  logic [9:0] v;
  initial begin
    forever #2 clk = ~clk;
  end
  bus_master_model i_bm (.i_core_clk(clk), .i_ack_valid(ackv), .i_ack(ack), .i_rdata_valid(rv),
    .i_rdata(rdat), .o_addr_valid(av), .o_addr(a), .o_rw(rw), .o_cmd_valid(cv), .o_cmd(c),
    .o_wdata_valid(wv), .o_wdata(wd), .o_rdata_req(rq), .o_stop(sp));
  hot_swap_regmap i_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_clk_en(1'b1),
    .i_strap_pin_low_order(s_lo), .i_strap_pin_high_order(s_hi), .i_multipurpose_good_pin(pg),
    .i_board_present_n(bp_n), .i_undervolt_high_input(undervolt_high_input), .i_undervolt_low_input(undervolt_low_input),
    .i_overvolt_input(ov), .i_fet_on(fet), .i_sense_above_2mv(sense), .i_power_bad(pbad),
    .i_overcurrent(oc), .i_alert_active(alert), .i_fault_set(fset), .i_adc_load(ld),
    .i_adc_chan(ch), .i_adc_value(val), .i_addr_valid(av), .i_addr(a), .i_addr_rw(rw),
    .i_cmd_valid(cv), .i_cmd_byte(c), .i_wdata_valid(wv), .i_wdata(wd), .i_rdata_req(rq),
    .i_stop(sp), .o_addr_ack_valid(ackv), .o_addr_ack(ack), .o_rdata_valid(rv), .o_rdata(rdat),
    .o_two_wire_enable(twe), .o_own_addr(own), .o_fault_log(fl), .o_alert_enable(ae),
    .o_switch_control(sc));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    // Strap table sweep, broadcast last
    for (int i = 0; i < 9; i++) begin
      s_hi <= hi_tab[i];
      s_lo <= lo_tab[i];
      repeat (4) @(posedge clk);
      #1;
      chk({7'h00, twe}, {7'h00, i != 8});
      if (i < 8) chk({1'b0, own}, 8'h10 | 8'(i));
    end
    i_bm.step(3'h0, 8'h10);
    chk({7'h00, i_bm.last_ack}, 8'h00);
    s_hi <= 2'h3;
    s_lo <= 2'h0;
    repeat (4) @(posedge clk);
    #1;
    chk({1'b0, own}, 8'h14);
    s_hi <= 2'h0;
    s_lo <= 2'h0;
    repeat (4) @(posedge clk);
    // Read/write registers, command high nibble ignored
    for (int r = 1; r < 4; r++) begin
      i_bm.wr(7'h10, {4'ha, 4'(r)}, 8'h96 ^ 8'(r));
      i_bm.rd(7'h10, {4'h5, 4'(r)});
      chk(i_bm.last_data, 8'h96 ^ 8'(r));
    end
    #1;
    chk(sc, 8'h95);
    chk(ae, 8'h94);
    // Receive byte repeats the kept pointer
    i_bm.rd(7'h10, 8'h02);
    i_bm.step(3'h1, 8'h10);
    i_bm.step(3'h4, 8'h00);
    chk(i_bm.last_data, 8'h94);
    i_bm.step(3'h4, 8'h00);
    chk(i_bm.last_data, 8'h94);
    i_bm.step(3'h5, 8'h00);
    // Fault event sets a log bit
    i_bm.wr(7'h10, 8'h01, 8'h00);
    @(posedge clk);
    fset <= 8'h40;
    @(posedge clk);
    fset <= 8'h00;
    i_bm.rd(7'h10, 8'h01);
    chk(i_bm.last_data, 8'h40);
    chk(fl, 8'h40);
    // Live status with general input configured, switch commanded off
    i_bm.wr(7'h10, 8'h03, 8'hc0);
    for (int k = 0; k < 2; k++) begin
      p = k ? 8'h5a : 8'ha5;
      {fet, pg, sense, bp_n, pbad, oc, ov} <= {p[7:2], p[0]};
      undervolt_high_input <= ~p[1];
      undervolt_low_input <= ~p[1];
      repeat (4) @(posedge clk);
      i_bm.wr(7'h10, 8'h00, ~p);
      i_bm.rd(7'h10, 8'h00);
      chk(i_bm.last_data, p);
    end
    // ADC results split high and low, locked then unlocked
    i_bm.wr(7'h10, 8'h03, 8'h00);
    for (int n = 0; n < 3; n++) begin
      v = 10'h2a5 ^ 10'({n, 8'h00});
      @(posedge clk);
      ld <= 1'b1;
      ch <= 2'(n);
      val <= v;
      @(posedge clk);
      ld <= 1'b0;
      i_bm.rd(7'h10, 8'h04 + 8'(2 * n));
      chk(i_bm.last_data, v[9:2]);
      i_bm.rd(7'h10, 8'h05 + 8'(2 * n));
      chk(i_bm.last_data, {6'h00, v[1:0]});
    end
    i_bm.wr(7'h10, 8'h04, 8'h11);
    i_bm.rd(7'h10, 8'h04);
    chk(i_bm.last_data, 8'ha9);
    i_bm.wr(7'h10, 8'h03, 8'h20);
    i_bm.wr(7'h10, 8'h04, 8'h11);
    i_bm.rd(7'h10, 8'h04);
    chk(i_bm.last_data, 8'h11);
    // Unmapped place
    i_bm.wr(7'h10, 8'h0a, 8'h77);
    i_bm.rd(7'h10, 8'h0a);
    chk(i_bm.last_data, 8'h00);
    // Mass write
    i_bm.wr(7'h1f, 8'h03, 8'h08);
    #1;
    chk({7'h00, i_bm.addr_ack}, 8'h01);
    chk(sc, 8'h08);
    // Alert response only while alert is driven
    i_bm.step(3'h1, 8'h0c);
    chk({7'h00, i_bm.last_ack}, 8'h00);
    i_bm.step(3'h5, 8'h00);
    alert <= 1'b1;
    i_bm.step(3'h1, 8'h0c);
    chk({7'h00, i_bm.last_ack}, 8'h01);
    i_bm.step(3'h4, 8'h00);
    chk(i_bm.last_data, 8'h20);
    i_bm.step(3'h5, 8'h00);
    stop_test();
  end
endmodule : test_hot_swap_regmap
`default_nettype wire
